// [hdl/adc_i2c_pkg.sv]
// What the document requires of this block and its host
// (R1) Host holds the reset pin low the minimum width, then waits before bus use.
// (R2) Reset command byte 06h or 07h fully resets the device; bus stays usable.
// (R3) Acknowledge general call with write direction; a following 06h resets the device.
// (R4) Host must send start/sync after every conversion-mode change.
// (R5) Single-shot converts once per start/sync, then returns to low power.
// (R6) Single-shot: configuration write during conversion aborts it and starts afresh.
// (R7) Continuous: each result is stored and the next conversion starts at once.
// (R8) First conversion begins 28.5 oscillator periods after start/sync is latched.
// (R9) Continuous: configuration write during conversion restarts that conversion.
// (R10) Power-down lets a running conversion finish, then stops; commands still answered.
// (R11) Start/sync in power-down wakes the device in the selected conversion mode.
// (R12) Slave address is 100, upper strap code, lower strap code.
// (R13) Straps are sampled again between each START and the first clock fall.
// (R14) Device is slave only and never drives the clock line.
// (R15) Data changes only while clock is low, except START and STOP.
// (R16) START is data falling with clock high; STOP is data rising with clock high.
// (R17) Address plus direction bit; device pulls data low on ninth pulse if matched.
// (R18) Bytes go MSB first, unlimited count; receiver acknowledges each byte.
// (R19) Ready output goes low on a new result, high once it is latched for reading.
// (R20) Continuous: unread result makes ready release briefly before the next result.
// (R21) Standard, fast and fast-plus rates are supported; high-speed mode is not.
// (R22) Idle 14000 modulator periods mid-transaction resets the bus interface.
// (R23) Commands take effect on the eighth falling clock edge of the command byte.
// (R24) Timing comes from a 1.024 MHz oscillator; modulator clock is a quarter.
// (R25) Command 0000 100x is start/sync.
// (R26) Command 0000 001x is power-down.
// (R27) Timeout count restarts on every clock transition and stays cleared when idle.
// (R28) While the reset pin is low, bus is ignored and configuration held at default.
// (R29) Results are 16-bit two's complement values.
`default_nettype none

package adc_i2c_pkg;
    localparam longint SYS_CLK_HZ = 250_000_000;
    localparam longint OSC_HZ = 1_024_000;
    localparam longint MOD_HZ = OSC_HZ / 4; // R24
    // Start delay held in tenths of an oscillator period, so 285 means 28.5.
    localparam longint START_DELAY_OSC_X10 = 285;
    localparam longint START_DELAY_CYC =
        (START_DELAY_OSC_X10 * SYS_CLK_HZ + 10 * OSC_HZ - 1) / (10 * OSC_HZ);
    localparam longint TIMEOUT_MOD = 14000;
    localparam longint TIMEOUT_CYC = TIMEOUT_MOD * SYS_CLK_HZ / MOD_HZ;
    localparam longint READY_RELEASE_NS = 1000;
    localparam longint READY_RELEASE_CYC = (READY_RELEASE_NS * SYS_CLK_HZ + 999_999_999)
        / 1_000_000_000;
    localparam logic [7:0] READY_RELEASE = 8'(READY_RELEASE_CYC);

    localparam logic [2:0] ADDR_PREFIX   = 3'h4;
    localparam logic [7:0] GC_WRITE      = 8'h00;
    localparam logic [7:0] GC_RESET_BYTE = 8'h06;
    localparam logic [6:0] CMD_RESET     = 7'h03;
    localparam logic [6:0] CMD_START     = 7'h04;
    localparam logic [6:0] CMD_SLEEP     = 7'h01;
    localparam logic [3:0] CMD_RDATA     = 4'h1;
    localparam logic [4:0] CMD_RREG      = 5'h04;
    localparam logic [5:0] CMD_WREG      = 6'h10;
    localparam int         RREG_SEL_BIT  = 2;
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam int         CFG_MODE_BIT  = 1;

    typedef enum logic [2:0] {
        BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_WR, BUS_WR_ACK, BUS_RD, BUS_RD_ACK, BUS_WAIT
    } bus_state_t;

    typedef enum logic [1:0] {SEQ_SLEEP, SEQ_DELAY, SEQ_CONV} seq_state_t;
endpackage

`default_nettype wire

// [hdl/bus_edge_detect.sv]
`default_nettype none

module bus_edge_detect
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic sclIn,
    input  wire logic sdaIn,
    output logic      sclRise,
    output logic      sclFall,
    output logic      startEv,
    output logic      stopEv
);
    logic sclPrev;
    logic sdaPrev;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end
        else
        begin
            // Even at fast-mode plus a bus phase spans well over a hundred clocks,
            // so plain oversampling suffices; high-speed mode is not supported.
            sclPrev <= sclIn; // R21
            sdaPrev <= sdaIn;
        end
    end

    assign sclRise = !sclPrev && sclIn;
    assign sclFall = sclPrev && !sclIn;
    assign startEv = sclPrev && sclIn && sdaPrev && !sdaIn; // R16
    assign stopEv  = sclPrev && sclIn && !sdaPrev && sdaIn; // R16
endmodule // bus_edge_detect

`default_nettype wire

// [hdl/conv_sequencer.sv]
`default_nettype none

module conv_sequencer
    import adc_i2c_pkg::*;
#(
    parameter int START_DELAY = 8
)
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic softRst,
    input  wire logic startCmd,
    input  wire logic sleepCmd,
    input  wire logic cfgWrite,
    input  wire logic contMode,
    input  wire logic convDone,
    output logic      convStart,
    output logic      analogOn
);
    seq_state_t  state;
    logic [15:0] dlyCnt;
    logic        sleepPending;

    wire dlyDone = state == SEQ_DELAY && dlyCnt == 16'(START_DELAY - 1);
    wire restart = state == SEQ_CONV && cfgWrite && !convDone;
    wire chain   = state == SEQ_CONV && convDone && contMode && !sleepPending && !sleepCmd;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state        <= SEQ_SLEEP;
            dlyCnt       <= 16'h0000;
            sleepPending <= 1'b0;
            convStart    <= 1'b0;
            analogOn     <= 1'b0;
        end
        else if (softRst)
        begin
            state        <= SEQ_SLEEP;
            dlyCnt       <= 16'h0000;
            sleepPending <= 1'b0;
            convStart    <= 1'b0;
            analogOn     <= 1'b0;
        end
        else
        begin
            convStart <= dlyDone || restart || chain; // R6 R7 R9
            if (startCmd) // R11
            begin
                state        <= SEQ_DELAY;
                dlyCnt       <= 16'h0000;
                sleepPending <= 1'b0;
                analogOn     <= 1'b1;
            end
            else
            begin
                case (state)
                    SEQ_DELAY:
                    begin
                        // A power-down in the very cycle the conversion begins lets it finish.
                        if (dlyDone) // R8
                        begin
                            state        <= SEQ_CONV;
                            sleepPending <= sleepCmd; // R10
                        end
                        else if (sleepCmd)
                        begin
                            state    <= SEQ_SLEEP;
                            analogOn <= 1'b0;
                        end
                        else
                            dlyCnt <= dlyCnt + 16'h0001;
                    end
                    SEQ_CONV:
                    begin
                        if (sleepCmd)
                            sleepPending <= 1'b1; // R10
                        if (convDone && !chain) // R5
                        begin
                            state        <= SEQ_SLEEP;
                            sleepPending <= 1'b0;
                            analogOn     <= 1'b0;
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    startDelay_a: // R8
    assert property (@(posedge clk) disable iff (rst)
        dlyDone && !softRst && !startCmd |=> convStart && state == SEQ_CONV)
        else $error("Conversion did not begin after the start delay.");

    contChain_a: // R7
    assert property (@(posedge clk) disable iff (rst)
        chain && !softRst && !startCmd |=> convStart && analogOn)
        else $error("Continuous mode did not chain the next conversion.");

    singleStop_a: // R5
    assert property (@(posedge clk) disable iff (rst)
        state == SEQ_CONV && convDone && !contMode && !startCmd |=> !analogOn ##1 !convStart)
        else $error("Single-shot conversion did not return to low power.");

    sleepFinish_a: // R10
    assert property (@(posedge clk) disable iff (rst)
        state == SEQ_CONV && sleepCmd && !convDone && !softRst && !startCmd |=> analogOn)
        else $error("Power-down cut a running conversion short.");
endmodule // conv_sequencer

`default_nettype wire

// [hdl/adc_i2c_slave.sv]
`default_nettype none

module adc_i2c_slave
    import adc_i2c_pkg::*;
#(
    parameter int START_DELAY = int'(START_DELAY_CYC),
    parameter int TIMEOUT     = int'(TIMEOUT_CYC)
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        resetPinN,
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    input  wire logic [1:0]  addrStrapHi,
    input  wire logic [1:0]  addrStrapLo,
    input  wire logic        convDone,
    input  wire logic [15:0] convResult,
    output logic             convStart,
    output logic             analogOn,
    output logic [7:0]       cfgReg,
    output logic             resultReadyNOe
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    logic        sclRise;
    logic        sclFall;
    logic        startEv;
    logic        stopEv;
    bus_state_t  busState;
    logic [3:0]  bitCnt;
    logic [7:0]  shiftIn;
    logic [15:0] txWord;
    logic [1:0]  strapHi;
    logic [1:0]  strapLo;
    logic        isGc;
    logic        cfgNext;
    logic [23:0] idleCnt;
    logic [15:0] latest;
    logic [15:0] pending;
    logic [7:0]  relCnt;

    bus_edge_detect u_edge (
        .clk     (clk),
        .rst     (rst),
        .sclIn   (sclIn), // R14
        .sdaIn   (sdaIn),
        .sclRise (sclRise),
        .sclFall (sclFall),
        .startEv (startEv),
        .stopEv  (stopEv)
    );

    wire [6:0] ownAddr     = {ADDR_PREFIX, strapHi, strapLo}; // R12
    wire       byteDone    = sclFall && bitCnt == 4'h8; // R23
    wire       addrHit     = shiftIn[7:1] == ownAddr;
    wire       gcHit       = shiftIn == GC_WRITE; // R3
    wire       wrByte      = byteDone && busState == BUS_WR;
    wire       cmdLatch    = wrByte && !isGc && !cfgNext;
    wire       resetCmd    = cmdLatch && shiftIn[7:1] == CMD_RESET; // R2
    wire       gcReset     = wrByte && isGc && shiftIn == GC_RESET_BYTE; // R3
    wire       startCmd    = cmdLatch && shiftIn[7:1] == CMD_START; // R25
    wire       sleepCmd    = cmdLatch && shiftIn[7:1] == CMD_SLEEP; // R26
    wire       rdataCmd    = cmdLatch && shiftIn[7:4] == CMD_RDATA;
    wire       rregCmd     = cmdLatch && shiftIn[7:3] == CMD_RREG;
    wire       wregCmd     = cmdLatch && shiftIn[7:2] == CMD_WREG;
    wire       cfgWrite    = wrByte && !isGc && cfgNext;
    wire       softRst     = !resetPinN || resetCmd || gcReset; // R28
    wire       idleTimeout = busState != BUS_IDLE && idleCnt == 24'(TIMEOUT - 1); // R22
    wire [7:0] regValue    = shiftIn[RREG_SEL_BIT] ? {resultReadyNOe, 7'h00} : cfgReg;

    // The master owns the clock, so the device only ever drives data low.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busState <= BUS_IDLE;
            bitCnt   <= 4'h0;
            shiftIn  <= 8'h00;
            txWord   <= 16'h0000;
            strapHi  <= 2'h0;
            strapLo  <= 2'h0;
            isGc     <= 1'b0;
            cfgNext  <= 1'b0;
            sdaOe    <= 1'b0;
            sdaOut   <= 1'b0;
        end
        else if (!resetPinN || idleTimeout) // R22 R28
        begin
            busState <= BUS_IDLE;
            cfgNext  <= 1'b0;
            sdaOe    <= 1'b0;
        end
        else if (startEv)
        begin
            busState <= BUS_ADDR;
            bitCnt   <= 4'h0;
            cfgNext  <= 1'b0;
            sdaOe    <= 1'b0;
            strapHi  <= addrStrapHi; // R13
            strapLo  <= addrStrapLo; // R13
        end
        else if (stopEv)
        begin
            busState <= BUS_IDLE;
            cfgNext  <= 1'b0;
            sdaOe    <= 1'b0;
        end
        else
        begin
            if (rdataCmd)
                txWord <= latest; // R29
            if (rregCmd)
                txWord <= {regValue, regValue};
            case (busState)
                BUS_ADDR, BUS_WR:
                begin
                    if (sclRise)
                    begin
                        shiftIn <= {shiftIn[6:0], sdaIn}; // R18
                        bitCnt  <= bitCnt + 4'h1;
                    end
                    if (byteDone && busState == BUS_ADDR)
                    begin
                        isGc     <= gcHit;
                        sdaOe    <= addrHit || gcHit; // R17
                        busState <= (addrHit || gcHit) ? BUS_ADDR_ACK : BUS_WAIT;
                    end
                    else if (byteDone)
                    begin
                        cfgNext  <= wregCmd;
                        sdaOe    <= 1'b1; // R18
                        busState <= BUS_WR_ACK;
                    end
                end
                BUS_ADDR_ACK, BUS_WR_ACK, BUS_RD_ACK:
                begin
                    if (sclRise && busState == BUS_RD_ACK && sdaIn)
                        busState <= BUS_WAIT;
                    else if (sclFall)
                    begin
                        bitCnt <= 4'h0;
                        if (busState == BUS_WR_ACK || (busState == BUS_ADDR_ACK && !shiftIn[0]))
                        begin
                            sdaOe    <= 1'b0;
                            busState <= BUS_WR;
                        end
                        else
                        begin
                            sdaOe    <= !txWord[15]; // R15
                            txWord   <= {txWord[14:0], txWord[15]};
                            busState <= BUS_RD;
                        end
                    end
                end
                BUS_RD:
                begin
                    if (sclFall && bitCnt == 4'h7)
                    begin
                        sdaOe    <= 1'b0;
                        busState <= BUS_RD_ACK;
                    end
                    else if (sclFall)
                    begin
                        sdaOe  <= !txWord[15]; // R15
                        txWord <= {txWord[14:0], txWord[15]};
                        bitCnt <= bitCnt + 4'h1;
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            idleCnt <= 24'h000000;
        else if (busState == BUS_IDLE || sclRise || sclFall || idleTimeout) // R27
            idleCnt <= 24'h000000;
        else
            idleCnt <= idleCnt + 24'h000001;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cfgReg <= CFG_RESET;
        else if (softRst) // R2 R3 R28
            cfgReg <= CFG_RESET;
        else if (cfgWrite)
            cfgReg <= shiftIn;
    end

    // A result that lands while an old one is unread waits out the release
    // pulse in a holding word, so the host always sees a fresh falling edge.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            resultReadyNOe <= 1'b0;
            relCnt         <= 8'h00;
            latest         <= 16'h0000;
            pending        <= 16'h0000;
        end
        else if (softRst)
        begin
            resultReadyNOe <= 1'b0;
            relCnt         <= 8'h00;
        end
        else
        begin
            if (rdataCmd)
                resultReadyNOe <= 1'b0; // R19
            if (convDone && resultReadyNOe)
            begin
                resultReadyNOe <= 1'b0; // R20
                relCnt         <= READY_RELEASE;
                pending        <= convResult;
            end
            else if (convDone)
            begin
                latest         <= convResult;
                resultReadyNOe <= 1'b1; // R19
            end
            else if (relCnt != 8'h00)
            begin
                relCnt <= relCnt - 8'h01;
                if (relCnt == 8'h01)
                begin
                    latest         <= pending;
                    resultReadyNOe <= 1'b1; // R20
                end
            end
        end
    end

    conv_sequencer #(
        .START_DELAY (START_DELAY)
    ) u_seq (
        .clk       (clk),
        .rst       (rst),
        .softRst   (softRst),
        .startCmd  (startCmd),
        .sleepCmd  (sleepCmd),
        .cfgWrite  (cfgWrite),
        .contMode  (cfgReg[CFG_MODE_BIT]),
        .convDone  (convDone),
        .convStart (convStart),
        .analogOn  (analogOn)
    );

    ackOnlyMatch_a: // R17
    assert property (byteDone && busState == BUS_ADDR && !addrHit && !gcHit
        && resetPinN && !idleTimeout |=> !sdaOe && busState == BUS_WAIT)
        else $error("Address acknowledged without a match.");

    gcAck_a: // R3
    assert property (byteDone && busState == BUS_ADDR && gcHit && resetPinN && !idleTimeout
        |=> sdaOe && busState == BUS_ADDR_ACK)
        else $error("General call was not acknowledged.");

    sdaHold_a: // R15
    assert property (sclIn && $past(sclIn) && $past(resetPinN)
        && !$past(startEv || stopEv || idleTimeout) |-> $stable(sdaOe))
        else $error("Data line moved while the clock was high.");

    cmdReset_a: // R2
    assert property (resetCmd || gcReset |=> cfgReg == CFG_RESET && !analogOn)
        else $error("Reset command did not reset the device.");

    strapSample_a: // R13
    assert property (startEv && resetPinN && !idleTimeout
        |=> ownAddr == {ADDR_PREFIX, $past(addrStrapHi), $past(addrStrapLo)})
        else $error("Address straps not sampled at START.");

    wakeOnCmd_a: // R23
    assert property ($rose(analogOn) |-> $past(startCmd))
        else $error("Converter woke without a latched start command.");

    readyLatch_a: // R19
    assert property (rdataCmd && !convDone && relCnt == 8'h00 |=> !resultReadyNOe)
        else $error("Ready did not release when the result was latched.");

    readyRelease_a: // R20
    assert property (convDone && resultReadyNOe && !softRst |=> !resultReadyNOe [*4])
        else $error("Unread result did not give a release pulse.");

    pinReset_a: // R28
    assert property (!resetPinN |=> !sdaOe && busState == BUS_IDLE && cfgReg == CFG_RESET)
        else $error("Bus not ignored while the reset pin is low.");

    timeout_a: // R22
    assert property (idleTimeout |=> busState == BUS_IDLE && !sdaOe && idleCnt == 24'h000000)
        else $error("Interface did not reset on timeout.");
endmodule // adc_i2c_slave

`default_nettype wire

// [verif/i2c_master_model.sv]
`default_nettype none

module i2c_master_model
(
    input  wire logic clk,
    input  wire logic sdaLine,
    output logic      scl,
    output logic      sdaPull
);
    timeunit 1ns;
    timeprecision 100ps;

    // Four clocks a phase keeps clear of the device's one-clock answer delay.
    task automatic phase();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic startCond();
        sdaPull = 1'b0;
        phase();
        scl = 1'b1;
        phase();
        sdaPull = 1'b1;
        phase();
        scl = 1'b0;
        phase();
    endtask

    task automatic stopCond();
        sdaPull = 1'b1;
        phase();
        scl = 1'b1;
        phase();
        sdaPull = 1'b0;
        phase();
    endtask

    // Data moves one clock after the fall so it never changes while the clock is high.
    task automatic xbyte(input logic [7:0] d, input logic b9, output logic [7:0] q,
                         output logic r9);
        logic [8:0] sh;
        logic [8:0] got;
        sh = {d, b9};
        for (int i = 8; i >= 0; i--)
        begin
            sdaPull = ~sh[i];
            phase();
            scl = 1'b1;
            phase();
            got[i] = sdaLine;
            scl = 1'b0;
            @(posedge clk);
            #1;
        end
        q = got[8:1];
        r9 = got[0];
    endtask

    initial
    begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
endmodule // i2c_master_model

`default_nettype wire

// [verif/tb_top.sv]
`default_nettype none

module tb_top
    import adc_i2c_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SD = 4;
    localparam int TO = 200;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        resetPinN = 1'b1;
    logic [1:0]  strapHi = 2'h0;
    logic [1:0]  strapLo = 2'h0;
    logic        convDone = 1'b0;
    logic [15:0] convResult = 16'h0000;
    logic        scl;
    logic        sdaPull;
    logic        sdaOut;
    logic        sdaOe;
    logic        convStart;
    logic        analogOn;
    logic [7:0]  cfgReg;
    logic        resultReadyNOe;
    wire logic   sdaLine;
    logic [7:0]  q;
    logic        r9;
    logic [15:0] w;
    logic        onPrev = 1'b0;
    int          mismatches = 0;
    int          nChecks = 0;
    int          nStarts = 0;
    int          cyc = 0;
    int          tOn = 0;
    int          tSt = 0;
    int          lastRes = 0;
    int          expCfg = 0;

    assign sdaLine = !(sdaPull || (sdaOe && !sdaOut));
    always #2 clk = ~clk;

    adc_i2c_slave #(.START_DELAY(SD), .TIMEOUT(TO)) dut_u
    (
        .clk(clk), .rst(rst), .resetPinN(resetPinN), .sclIn(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrapHi(strapHi), .addrStrapLo(strapLo),
        .convDone(convDone), .convResult(convResult), .convStart(convStart),
        .analogOn(analogOn), .cfgReg(cfgReg), .resultReadyNOe(resultReadyNOe)
    );

    i2c_master_model mst (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaPull(sdaPull));

    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (analogOn === 1'b1 && onPrev !== 1'b1)
            tOn = cyc;
        if (convStart === 1'b1)
        begin
            nStarts = nStarts + 1;
            tSt = cyc;
        end
        onPrev = analogOn;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic waitStarts(input int n);
        for (int i = 0; i < 3000; i++)
        begin
            if (nStarts >= n)
                return;
            tick(1);
        end
        mismatches++;
        final_report();
    endtask

    task automatic endConv(input logic [15:0] d);
        convDone = 1'b1;
        convResult = d;
        lastRes = d;
        tick(1);
        convDone = 1'b0;
    endtask

    // The model keeps its own copy of the configuration byte for the check at the end of each write frame.
    task automatic wrFrame(input logic [7:0] b0, input logic [7:0] b1, input int n);
        mst.startCond();
        mst.xbyte({3'h4, strapHi, strapLo, 1'b0}, 1'b1, q, r9);
        chk("addr ack", 16'(r9), 16'h0000);
        mst.xbyte(b0, 1'b1, q, r9);
        chk("cmd ack", 16'(r9), 16'h0000);
        if (n > 1)
        begin
            mst.xbyte(b1, 1'b1, q, r9);
            expCfg = b1;
        end
        if (b0[7:1] == 7'h03)
            expCfg = 0;
        mst.stopCond();
        chk("cfg", 16'(cfgReg), 16'(expCfg));
    endtask

    task automatic rdWord(output logic [15:0] d);
        mst.startCond();
        mst.xbyte({3'h4, strapHi, strapLo, 1'b1}, 1'b1, q, r9);
        chk("read addr ack", 16'(r9), 16'h0000);
        mst.xbyte(8'hFF, 1'b0, d[15:8], r9);
        mst.xbyte(8'hFF, 1'b1, d[7:0], r9);
        mst.stopCond();
    endtask

    initial
    begin
        void'($urandom(32'hB81C));
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        tick(2);
        for (int i = 0; i < 4; i++)
        begin
            {strapHi, strapLo} = 4'($urandom());
            mst.startCond();
            mst.xbyte({3'h4, strapHi, strapLo ^ 2'h1, 1'b0}, 1'b1, q, r9);
            chk("foreign addr nack", 16'(r9), 16'h0001);
            mst.stopCond();
            wrFrame(8'h20, 8'h00, 1);
            rdWord(w);
            chk("cfg read", w, 16'h0000);
        end
        wrFrame(8'h09, 8'h00, 1);
        waitStarts(1);
        chk("start delay", 16'(tSt - tOn), 16'(SD));
        wrFrame(8'h40, 8'h00, 2);
        chk("single restart", 16'(nStarts), 16'h0002);
        endConv(16'($urandom()));
        chk("single off", 16'(analogOn), 16'h0000);
        chk("ready low", 16'(resultReadyNOe), 16'h0001);
        wrFrame(8'h24, 8'h00, 1);
        rdWord(w);
        chk("status", w, 16'h8080);
        wrFrame(8'h10, 8'h00, 1);
        chk("ready high", 16'(resultReadyNOe), 16'h0000);
        rdWord(w);
        chk("result", w, 16'(lastRes));
        wrFrame(8'h40, 8'h02, 2);
        wrFrame(8'h08, 8'h00, 1);
        waitStarts(3);
        wrFrame(8'h43, 8'h02, 2);
        chk("cont restart", 16'(nStarts), 16'h0004);
        endConv(16'($urandom()));
        chk("cont next", 16'(convStart), 16'h0001);
        tick(20);
        endConv(16'($urandom()));
        chk("ready release", 16'(resultReadyNOe), 16'h0000);
        tick(int'(READY_RELEASE_CYC) + 5);
        chk("ready again", 16'(resultReadyNOe), 16'h0001);
        wrFrame(8'h10, 8'h00, 1);
        rdWord(w);
        chk("held result", w, 16'(lastRes));
        wrFrame(8'h03, 8'h00, 1);
        chk("sleep waits", 16'(analogOn), 16'h0001);
        endConv(16'($urandom()));
        chk("sleep off", 16'(analogOn), 16'h0000);
        tick(2);
        chk("no conv asleep", 16'(nStarts), 16'h0006);
        wrFrame(8'h08, 8'h00, 1);
        chk("wake", 16'(analogOn), 16'h0001);
        waitStarts(7);
        mst.startCond();
        mst.xbyte(8'h00, 1'b1, q, r9);
        chk("gc ack", 16'(r9), 16'h0000);
        mst.xbyte(8'h06, 1'b1, q, r9);
        mst.stopCond();
        expCfg = 0;
        chk("gc reset", 16'({analogOn, cfgReg}), 16'h0000);
        wrFrame(8'h40, 8'h02, 2);
        wrFrame(8'h07, 8'h00, 1);
        wrFrame(8'h40, 8'h02, 2);
        wrFrame(8'h06, 8'h00, 1);
        mst.startCond();
        mst.xbyte({3'h4, strapHi, strapLo, 1'b0}, 1'b1, q, r9);
        tick(TO + 20);
        mst.xbyte(8'h40, 1'b1, q, r9);
        chk("timeout idle", 16'(r9), 16'h0001);
        mst.stopCond();
        wrFrame(8'h40, 8'h02, 2);
        resetPinN = 1'b0;
        tick(2);
        chk("pin reset cfg", 16'(cfgReg), 16'h0000);
        mst.startCond();
        mst.xbyte({3'h4, strapHi, strapLo, 1'b0}, 1'b1, q, r9);
        chk("pin reset nack", 16'(r9), 16'h0001);
        mst.stopCond();
        resetPinN = 1'b1;
        tick(4);
        expCfg = 0;
        wrFrame(8'h20, 8'h00, 1);
        final_report();
    end
endmodule // tb_top

`default_nettype wire
